// ### pfc_feature_ctl.v
// feature control register, output steering and phase detect wrapper
`timescale 1ns/1ps
`include "pfc_map.vh"
module pfc_feature_ctl (
  // clock and reset
  input  wire        mclk_in,
  input  wire        reset_in,
  // programming port mode straps
  input  wire        enh_n_in,
  input  wire        bmode_in,
  input  wire        smode_in,
  // parallel programming
  input  wire [7:0]  par_data_in,
  input  wire        feat_wr_in,
  // serial programming
  input  wire        sclk_in,
  input  wire        sdata_in,
  input  wire        ser_wr_in,
  // internal synthesizer signals
  input  wire        fp_raw_in,
  input  wire        fc_raw_in,
  input  wire        modulus_select_in,
  input  wire        prescaler_in,
  // divided clock and diagnostic outputs
  output reg         fp_out,
  output reg         fc_out,
  output reg         diag_out,
  // phase detector outputs
  output reg         pump_up_n_out,
  output reg         pump_down_n_out,
  output reg         lock_integ_out,
  output reg         lock_indicator_out,
  // control state
  output reg         power_down_out,
  output reg         counter_load_out,
  output reg  [7:0]  feature_reg_out
);

  // ----------------------------------------------------------------
  // strobe and clock edge detection
  // ----------------------------------------------------------------
  // pins are synchronous, so a single previous-sample flop is enough
  reg feat_wr_d;
  reg sclk_d;
  reg fp_d;
  reg fc_d;

  always @(posedge mclk_in) begin
    if (reset_in) begin
      feat_wr_d <= 1'b0;
      sclk_d    <= 1'b0;
      fp_d      <= 1'b0;
      fc_d      <= 1'b0;
    end else begin
      feat_wr_d <= feat_wr_in;
      sclk_d    <= sclk_in;
      fp_d      <= fp_raw_in;
      fc_d      <= fc_raw_in;
    end
  end

  wire feat_wr_rise = feat_wr_in & ~feat_wr_d;
  wire feat_wr_fall = ~feat_wr_in & feat_wr_d;
  wire sclk_rise    = sclk_in & ~sclk_d;
  wire fp_rise      = fp_raw_in & ~fp_d;
  wire fc_rise      = fc_raw_in & ~fc_d;

  // ----------------------------------------------------------------
  // programming port: parallel latch and serial shift with buffer
  // ----------------------------------------------------------------
  // the feature byte path depends on smode only; bmode is don't-care
  reg  [7:0]                 feat_reg;
  reg  [7:0]                 ser_shift;
  reg  [`PFC_SER_CNT_W-1:0]  ser_count;
  reg  [7:0]                 next_feat;
  reg  [7:0]                 next_shift;
  reg  [`PFC_SER_CNT_W-1:0]  next_count;

  wire par_mode = ~smode_in;
  wire ser_mode = smode_in;
  // shifting only while the feature strobe is high and counter strobe low
  wire ser_shift_en = ser_mode & feat_wr_in & ~ser_wr_in & sclk_rise;

  // port stays alive during power-down, so writes are never gated by it
  always @* begin
    next_feat  = feat_reg;
    next_shift = ser_shift;
    next_count = ser_count;
    if (par_mode && feat_wr_rise) begin
      next_feat = par_data_in;
    end
    if (ser_shift_en) begin
      // first bit lands in bit 7 after eight shifts
      next_shift = {ser_shift[6:0], sdata_in};
      if (ser_count != `PFC_SER_BITS)
        next_count = ser_count + 4'h1;
    end
    if (ser_mode && feat_wr_fall) begin
      // buffer capture keeps control bits steady during shifting
      next_feat  = ser_shift;
      next_count = {`PFC_SER_CNT_W{1'b0}};
    end
  end

  always @(posedge mclk_in) begin
    if (reset_in) begin
      feat_reg  <= `PFC_FEAT_RESET;
      ser_shift <= 8'h00;
      ser_count <= {`PFC_SER_CNT_W{1'b0}};
    end else begin
      feat_reg  <= next_feat;
      ser_shift <= next_shift;
      ser_count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // effective feature bits
  // ----------------------------------------------------------------
  // bits only act while the enhancement enable is held low
  function feat_active;
    input [7:0] regval;
    input       enh_n;
    input integer pos;
    begin
      feat_active = regval[pos] & ~enh_n;
    end
  endfunction

  wire en_pd    = feat_active(feat_reg, enh_n_in, `PFC_BIT_POWER_DOWN);
  wire en_load  = feat_active(feat_reg, enh_n_in, `PFC_BIT_CNT_LOAD);
  wire en_modulus_select  = feat_active(feat_reg, enh_n_in, `PFC_BIT_MODULUS_SELECT_OUT);
  wire en_presc = feat_active(feat_reg, enh_n_in, `PFC_BIT_PRESC_OUT);
  wire en_odis  = feat_active(feat_reg, enh_n_in, `PFC_BIT_OUT_DIS);
  wire running  = ~en_pd;

  // ----------------------------------------------------------------
  // phase detector
  // ----------------------------------------------------------------
  wire up_req;
  wire down_req;

  pfc_phase_det u_phase_det (
    .mclk_in      (mclk_in),
    .reset_in     (reset_in),
    .enable_in    (running),
    .fp_rise_in   (fp_rise),
    .fc_rise_in   (fc_rise),
    .up_req_out   (up_req),
    .down_req_out (down_req)
  );

  // ----------------------------------------------------------------
  // output steering
  // ----------------------------------------------------------------
  reg next_diag;

  // prescaler view wins if software sets both diagnostic bits
  always @* begin
    next_diag = 1'b0;
    if (running) begin
      if (en_presc)
        next_diag = prescaler_in;
      else if (en_modulus_select)
        next_diag = modulus_select_in;
    end
  end

  // every output registered; adds one cycle to the pump path
  always @(posedge mclk_in) begin
    if (reset_in) begin
      fp_out             <= 1'b0;
      fc_out             <= 1'b0;
      diag_out           <= 1'b0;
      pump_up_n_out      <= 1'b1;
      pump_down_n_out    <= 1'b1;
      lock_integ_out     <= 1'b0;
      lock_indicator_out <= 1'b1;
      power_down_out     <= 1'b0;
      counter_load_out   <= 1'b0;
      feature_reg_out    <= `PFC_FEAT_RESET;
    end else begin
      fp_out             <= fp_raw_in & running & ~en_odis;
      fc_out             <= fc_raw_in & running & ~en_odis;
      diag_out           <= next_diag;
      pump_up_n_out      <= ~up_req;
      pump_down_n_out    <= ~down_req;
      // nand of the two active-low waveforms
      lock_integ_out     <= ~((~up_req) & (~down_req));
      lock_indicator_out <= (~up_req) & (~down_req);
      power_down_out     <= en_pd;
      // level held as long as the bit stays set and power-down is clear, no one-shot
      counter_load_out   <= en_load & running;
      feature_reg_out    <= feat_reg;
    end
  end

endmodule // pfc_feature_ctl

// ### pfc_map.vh
// constants and functional notes for the pll feature control block
// Functional notes
// - each feature bit is active when one, inactive when zero.
// - power-down stops everything except the programming port, which keeps taking writes.
// - counter-load bit loads counter programming immediately and continuously.
// - modulus-select-output bit steers modulus_select onto the diagnostic pin.
// - prescaler-output bit steers the raw prescaler output onto the diagnostic pin.
// - output-disable bit turns off divided main and reference clock outputs.
// - the phase detector reacts only to rising edges of both divided clocks.
// - main clock leading reference pulses pump_down_n low.
// - reference leading main clock pulses pump_up_n low.
// - pump pulse width tracks the phase offset between the divided clocks.
// - the lock integration node is the NAND of both pump waveforms.
// - lock_indicator is the AND of pump_up_n and pump_down_n.
// - feature bits act only while the enhancement enable input is low.
// - parallel mode latches the data byte on the write strobe rising edge.
// - serial mode shifts eight bits first-first, captured on strobe falling edge.
`ifndef PFC_MAP_VH
`define PFC_MAP_VH

// ----------------------------------------------------------------
// feature control register layout
// ----------------------------------------------------------------
`define PFC_FEAT_WIDTH      8
`define PFC_FEAT_RESET      8'h00
`define PFC_BIT_POWER_DOWN  3
`define PFC_BIT_CNT_LOAD    4
`define PFC_BIT_MODULUS_SELECT_OUT    5
`define PFC_BIT_PRESC_OUT   6
`define PFC_BIT_OUT_DIS     7
`define PFC_RSVD_MASK       8'h07

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define PFC_SER_BITS        8
`define PFC_SER_CNT_W       4
`define PFC_PUMP_CLR_CYCLES 1

`endif

// ### pfc_phase_det.v
// digital phase-frequency detector on edge pulses of the divided clocks
`timescale 1ns/1ps
`include "pfc_map.vh"
module pfc_phase_det (
  // clock and reset
  input  wire mclk_in,
  input  wire reset_in,
  // control
  input  wire enable_in,
  // edge events, one cycle each
  input  wire fp_rise_in,
  input  wire fc_rise_in,
  // pump requests, active high
  output wire up_req_out,
  output wire down_req_out
);

  reg up_q;
  reg down_q;
  reg next_up;
  reg next_down;

  // ----------------------------------------------------------------
  // tri-state detector: each edge sets its own flag, both flags clear
  // ----------------------------------------------------------------
  always @* begin
    next_up   = up_q;
    next_down = down_q;
    if (!enable_in) begin
      next_up   = 1'b0;
      next_down = 1'b0;
    end else if (up_q && down_q) begin
      // one-cycle clear interval once both edges have been seen
      next_up   = 1'b0;
      next_down = 1'b0;
    end else begin
      if (fc_rise_in)
        next_up = 1'b1;
      if (fp_rise_in)
        next_down = 1'b1;
      // coincident edges cancel, so no pulse for zero offset
      if (fc_rise_in && fp_rise_in && !up_q && !down_q) begin
        next_up   = 1'b0;
        next_down = 1'b0;
      end
    end
  end

  // flags stand from the leading edge to the lagging one
  always @(posedge mclk_in) begin
    if (reset_in) begin
      up_q   <= 1'b0;
      down_q <= 1'b0;
    end else begin
      up_q   <= next_up;
      down_q <= next_down;
    end
  end

  assign up_req_out   = up_q;
  assign down_req_out = down_q;

endmodule // pfc_phase_det

// ### pfc_host_model.sv
// host model driving the feature programming port
`timescale 1ns/1ps
module pfc_host_model (
  // clock
  input  wire       mclk_in,
  // programming port
  output reg        smode_out,
  output reg  [7:0] par_data_out,
  output reg        feat_wr_out,
  output reg        sclk_out,
  output reg        sdata_out
);
  // idle port at time zero
  initial begin
    {smode_out, par_data_out, feat_wr_out, sclk_out, sdata_out} = 12'h000;
  end
  // byte set up with the strobe rise; bus inverted once released
  task par_write(input logic [7:0] d);
    @(negedge mclk_in);
    smode_out = 1'b0;
    par_data_out = d & 8'hF8;
    feat_wr_out = 1'b1;
    @(negedge mclk_in);
    feat_wr_out = 1'b0;
    par_data_out = ~par_data_out;
    @(negedge mclk_in);
  endtask
  // top bit first so it lands in bit 7; capture on strobe fall
  task ser_write(input logic [7:0] d);
    integer i;
    @(negedge mclk_in);
    smode_out = 1'b1;
    feat_wr_out = 1'b1;
    for (i = 7; i >= 0; i = i - 1) begin
      @(negedge mclk_in);
      sdata_out = (i > 2) ? d[i] : 1'b0;
      @(negedge mclk_in);
      sclk_out = 1'b1;
      @(negedge mclk_in);
      sclk_out = 1'b0;
    end
    @(negedge mclk_in);
    feat_wr_out = 1'b0;
    repeat (2) @(negedge mclk_in);
    sdata_out = ~sdata_out;
  endtask
endmodule // pfc_host_model

// ### pfc_feature_ctl_sva.sv
// assertions on the feature control block ports
`timescale 1ns/1ps
module pfc_feature_ctl_sva (
  // clock, reset, inputs
  input wire       mclk_in,
  input wire       reset_in,
  input wire       enh_n_in,
  input wire       fp_raw_in,
  input wire       fc_raw_in,
  input wire       prescaler_in,
  input wire       modulus_select_in,
  // outputs
  input wire       fp_out,
  input wire       fc_out,
  input wire       diag_out,
  input wire       pump_up_n_out,
  input wire       pump_down_n_out,
  input wire       lock_integ_out,
  input wire       lock_indicator_out,
  input wire       power_down_out,
  input wire [7:0] feature_reg_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // lone rising edge while the detector is idle
  sequence s_fc_lead;
    $rose(fc_raw_in) && !fp_raw_in && pump_up_n_out && pump_down_n_out && !power_down_out;
  endsequence
  sequence s_fp_lead;
    $rose(fp_raw_in) && !fc_raw_in && pump_up_n_out && pump_down_n_out && !power_down_out;
  endsequence
  a_lock_and: assert property (lock_indicator_out == (pump_up_n_out && pump_down_n_out))
    else $error("lock indicator wrong");
  a_integ_nand: assert property (lock_integ_out == !(pump_up_n_out && pump_down_n_out))
    else $error("lock node wrong");
  a_pump_clear: assert property (!pump_up_n_out && !pump_down_n_out |=> pump_up_n_out && pump_down_n_out)
    else $error("pumps stuck low");
  a_up_lead: assert property (s_fc_lead |-> ##2 !pump_up_n_out && pump_down_n_out)
    else $error("no up pulse");
  a_down_lead: assert property (s_fp_lead |-> ##2 !pump_down_n_out && pump_up_n_out)
    else $error("no down pulse");
  a_out_dis: assert property (feature_reg_out[7] && !$past(enh_n_in) |-> !fp_out && !fc_out)
    else $error("clocks not disabled");
  a_diag_presc: assert property (feature_reg_out[6:3] == 4'h8 && !$past(enh_n_in)
    |-> diag_out == $past(prescaler_in)) else $error("diag not prescaler");
  a_diag_modulus_select: assert property (feature_reg_out[6:3] == 4'h4 && !$past(enh_n_in)
    |-> diag_out == $past(modulus_select_in)) else $error("diag not modulus");
  a_pdown_all: assert property (feature_reg_out[3] && !$past(enh_n_in)
    |-> power_down_out && pump_up_n_out && pump_down_n_out && !diag_out)
    else $error("power down incomplete");
  a_enh_off: assert property ($past(enh_n_in) |-> !power_down_out && !diag_out)
    else $error("feature acts while disabled");
endmodule // pfc_feature_ctl_sva
bind pfc_feature_ctl pfc_feature_ctl_sva u_sva (.mclk_in, .reset_in, .enh_n_in, .fp_raw_in,
  .fc_raw_in, .prescaler_in, .modulus_select_in, .fp_out, .fc_out, .diag_out, .pump_up_n_out,
  .pump_down_n_out, .lock_integ_out, .lock_indicator_out, .power_down_out, .feature_reg_out);

// ### pll_feature_control_and_phase_detect_bench.sv
// self-checking bench for the feature control and phase detect block
`timescale 1ns/1ps
module pll_feature_control_and_phase_detect_bench;
  reg        mclk_in, reset_in, enh_n_in, fp_raw_in, fc_raw_in, modulus_select_in, prescaler_in;
  reg        bmode_in, ser_wr_in;
  wire       smode_in, feat_wr_in, sclk_in, sdata_in, fp_out, fc_out, diag_out, lock_integ_out;
  wire       pump_up_n_out, pump_down_n_out, lock_indicator_out, power_down_out, counter_load_out;
  wire [7:0] par_data_in, feature_reg_out;
  integer    errors, comparisons, w1, w2;
  pfc_feature_ctl u_pfc_feature_ctl (.mclk_in, .reset_in, .enh_n_in, .bmode_in, .smode_in,
    .par_data_in, .feat_wr_in, .sclk_in, .sdata_in, .ser_wr_in, .fp_raw_in, .fc_raw_in,
    .modulus_select_in, .prescaler_in, .fp_out, .fc_out, .diag_out, .pump_up_n_out,
    .pump_down_n_out, .lock_integ_out, .lock_indicator_out, .power_down_out,
    .counter_load_out, .feature_reg_out);
  pfc_host_model u_pfc_host_model (.mclk_in, .smode_out(smode_in), .par_data_out(par_data_in),
    .feat_wr_out(feat_wr_in), .sclk_out(sclk_in), .sdata_out(sdata_in));
  // 20 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // registered outputs settle within two edges
  task wt;
    repeat (2) @(negedge mclk_in);
  endtask
  // lead one divided clock by k cycles and count low cycles of the leading pump
  task pd(input logic fc_lead, input integer k, output integer w);
    integer i;
    w = 0;
    @(negedge mclk_in);
    if (fc_lead) fc_raw_in = 1'b1;
    else fp_raw_in = 1'b1;
    for (i = 0; i < k + 8; i = i + 1) begin
      @(negedge mclk_in);
      if (i == k - 1) {fp_raw_in, fc_raw_in} = 2'b11;
      w = w + ((fc_lead ? pump_up_n_out : pump_down_n_out) === 1'b0);
    end
    {fp_raw_in, fc_raw_in} = 2'b00;
    @(negedge mclk_in);
  endtask
  task finish_test;
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog, far beyond the expected 175 or so cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    errors = errors + 1;
    finish_test;
  end
  // main sequence
  initial begin
    {reset_in, enh_n_in, fp_raw_in, fc_raw_in, modulus_select_in, prescaler_in} = 6'h20;
    {bmode_in, ser_wr_in} = 2'b00;
    errors = 0;
    comparisons = 0;
    repeat (12) @(negedge mclk_in);
    reset_in = 1'b0;
    wt;
    check("reset reg", feature_reg_out, 8'h00);
    check("reset pumps", {pump_up_n_out, pump_down_n_out, lock_indicator_out}, 8'h07);
    check("reset integ", lock_integ_out, 8'h00);
    u_pfc_host_model.par_write(8'h87);
    {fp_raw_in, fc_raw_in} = 2'b11; // coincident edges give no pulse
    wt;
    check("masked reg", feature_reg_out, 8'h80);
    check("clocks off", {fp_out, fc_out}, 8'h00);
    u_pfc_host_model.par_write(8'h00);
    wt;
    check("clocks on", {fp_out, fc_out}, 8'h03);
    {fp_raw_in, fc_raw_in} = 2'b00;
    prescaler_in = 1'b1;
    u_pfc_host_model.ser_write(8'h40);
    wt;
    check("serial reg", feature_reg_out, 8'h40);
    check("diag presc", diag_out, 8'h01);
    {modulus_select_in, prescaler_in} = 2'b10;
    bmode_in = 1'b1; // feature path ignores the mode strap
    u_pfc_host_model.ser_write(8'h20);
    bmode_in = 1'b0;
    wt;
    check("diag modulus_select", diag_out, 8'h01);
    enh_n_in = 1'b1;
    wt;
    check("diag gated", diag_out, 8'h00);
    enh_n_in = 1'b0;
    u_pfc_host_model.par_write(8'h08);
    pd(1, 3, w1);
    check("pd pump", w1, 8'h00);
    u_pfc_host_model.par_write(8'h18);
    wt;
    check("pd write", feature_reg_out, 8'h18);
    check("pd load", {power_down_out, counter_load_out}, 8'h02);
    u_pfc_host_model.par_write(8'h10);
    wt;
    check("load", {power_down_out, counter_load_out}, 8'h01);
    u_pfc_host_model.par_write(8'h00);
    pd(1, 3, w1);
    pd(1, 7, w2);
    check("up width", w2 - w1, 8'h04);
    check("up pulse", w1 > 2, 8'h01);
    pd(0, 2, w1);
    pd(0, 6, w2);
    check("down width", w2 - w1, 8'h04);
    check("down pulse", w1 > 1, 8'h01);
    wt;
    check("idle", {pump_up_n_out, pump_down_n_out}, 8'h03);
    finish_test;
  end
endmodule // pll_feature_control_and_phase_detect_bench
